// file: include/hrx_defines.svh
`ifndef HRX_DEFINES_SVH
`define HRX_DEFINES_SVH
// register byte offsets
`define HRX_OFS_CTRL   4'h0
`define HRX_OFS_THR    4'h4
`define HRX_OFS_STAT   4'h8
`define HRX_OFS_MSG    4'hC
// control register bits
`define HRX_CTRL_EN    0
`define HRX_CTRL_NFIE  1
`define HRX_CTRL_MSGIE 2
`define HRX_CTRL_OVRIE 3
// status register bits
`define HRX_ST_NF      0
`define HRX_ST_MSG     1
`define HRX_ST_OVR     2
`define HRX_ST_BLK     3
`define HRX_ST_GOOD    4
`define HRX_ST_NEXT    5
`define HRX_ST_IRQM    6
// threshold reset value and lower limit
`define HRX_THR_RST    7'h20
`define HRX_THR_MIN    7'h02
// runs of raw ones
`define HRX_ONES_STUFF 3'h5
`define HRX_ONES_FLAG  3'h6
`define HRX_ONES_SAT   3'h7
// unstuffed bit counts
`define HRX_FLAG_BITS  4'h7
`define HRX_EMIT_AT    4'hE
// block length limit before forced close
`define HRX_LEN_LAST   7'h7E
// errored status byte: error code in bits 6:5
`define HRX_ERR_ALIGN  2'h1
`define HRX_ERR_ABORT  2'h2
`define HRX_ERR_OVR    2'h3
`endif

// file: include/hrx_pkg.sv
package hrx_pkg;
  // deframer states, gray along hunt -> flagged -> data
  typedef enum logic [1:0] {
    HRX_HUNT  = 2'h0,
    HRX_FLAGD = 2'h1,
    HRX_DATA  = 2'h3
  } hrx_dfr_e;
  typedef logic [7:0] hrx_octet_t;
endpackage : hrx_pkg

// file: include/hrx_link_if.sv
`timescale 1ns/100ps
interface hrx_link_if;
  import hrx_pkg::*;
  logic       octet_vld;  // one-cycle pulse, octet holds a data byte
  hrx_octet_t octet;      // unstuffed data byte
  logic       sof;        // flag-to-data transition seen
  logic       eom;        // closing flag after data
  logic       align_err;  // with eom: bit count not whole octets
  logic       abrt;       // abort inside a message
  modport dfr  (output octet_vld, octet, sof, eom, align_err, abrt);
  modport fifo (input  octet_vld, octet, sof, eom, align_err, abrt);
endinterface : hrx_link_if

// file: hw/hrx_deframer.sv
`timescale 1ns/100ps
`include "hrx_defines.svh"
module hrx_deframer (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic enable,
  input  wire logic bit_en,
  input  wire logic bit_in,
  hrx_link_if.dfr   lk
);
  import hrx_pkg::*;
  hrx_dfr_e    st_r, st_nxt;   // framing state
  logic [2:0]  ones_r;         // run of raw ones, saturating
  logic [15:0] sr_r;           // unstuffed bits, newest at top
  logic [3:0]  cnt_r;          // unstuffed bits held since flag

  // a zero after five ones is stuffing, after six it closes a flag
  wire is_stuff = bit_en & ~bit_in & (ones_r == `HRX_ONES_STUFF); // RULE21
  wire is_flag  = bit_en & ~bit_in & (ones_r == `HRX_ONES_FLAG);  // RULE21
  wire is_abort = bit_en & bit_in & (ones_r == `HRX_ONES_FLAG);
  wire push     = bit_en & ~is_stuff & ~is_flag & ~is_abort & (st_r != HRX_HUNT);
  // the last seven pushed bits may still turn into a flag, so a byte
  // leaves only once fifteen bits are held
  wire emit     = push & (cnt_r == `HRX_EMIT_AT) & (st_r == HRX_DATA);
  wire go_data  = push & (cnt_r == `HRX_FLAG_BITS) & (st_r == HRX_FLAGD); // RULE21
  wire [15:0] sr_nxt = {bit_in, sr_r[15:1]};

  // next framing state
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      HRX_HUNT:  if (is_flag) st_nxt = HRX_FLAGD;
      HRX_FLAGD: if (is_abort) st_nxt = HRX_HUNT;
                 else if (go_data) st_nxt = HRX_DATA;
      HRX_DATA:  if (is_abort) st_nxt = HRX_HUNT; // RULE2
                 else if (is_flag) st_nxt = HRX_FLAGD;
      default:   st_nxt = HRX_HUNT;
    endcase
  end

  // bit-rate state; disable drops back to hunting
  always_ff @(posedge clk) begin
    if (!reset_n || !enable) begin
      st_r   <= HRX_HUNT;
      ones_r <= 3'h0;
      cnt_r  <= 4'h0;
      sr_r   <= 16'h0000;
    end else if (bit_en) begin
      st_r   <= st_nxt;
      ones_r <= !bit_in ? 3'h0 : (ones_r == `HRX_ONES_SAT) ? ones_r : ones_r + 3'h1;
      if (push) sr_r <= sr_nxt;
      if (is_flag || is_abort) cnt_r <= 4'h0;
      else if (emit) cnt_r <= `HRX_FLAG_BITS;
      else if (push && cnt_r != `HRX_EMIT_AT) cnt_r <= cnt_r + 4'h1;
    end
  end

  // event outputs, one-cycle pulses from flops
  always_ff @(posedge clk) begin
    if (!reset_n || !enable) begin
      lk.octet_vld <= 1'b0;
      lk.octet     <= 8'h00;
      lk.sof       <= 1'b0;
      lk.eom       <= 1'b0;
      lk.align_err <= 1'b0;
      lk.abrt      <= 1'b0;
    end else begin
      lk.octet_vld <= emit;
      if (emit) lk.octet <= sr_nxt[8:1];
      lk.sof       <= go_data;
      lk.eom       <= is_flag & (st_r == HRX_DATA);
      lk.align_err <= is_flag & (st_r == HRX_DATA) & (cnt_r != `HRX_FLAG_BITS);
      lk.abrt      <= is_abort & (st_r == HRX_DATA); // RULE1
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_hunt_after_abort;
    enable && is_abort |=> st_r == HRX_HUNT;
  endproperty
  a_hunt_after_abort: assert property (p_hunt_after_abort) else $error("no hunt after abort"); // RULE2
endmodule : hrx_deframer

// file: hw/hrx_rx_link_unit.sv
`timescale 1ns/100ps
`include "hrx_defines.svh"
// Summary of operation
// RULE1: abort ends message as errored, data dropped
// RULE2: after abort wait for flag then data
// RULE3: threshold reached closes partial block, sets near-full
// RULE4: next octet decides block after threshold byte
// RULE5: threshold on status slot gives empty partial
// RULE6: data into full FIFO: overrun, errored block
// RULE7: postponed status byte after read, always errored
// RULE8: overrun discards data until flag-to-data transition
// RULE9: message byte read pops next byte
// RULE10: open block never visible to the host
// RULE11: block-present flag; empty read leaves pointer
// RULE12: status byte first, then alternating with data
// RULE13: flag tells whether next byte is status
// RULE14: host reads status before each status byte
// RULE15: functional interrupt enables select interrupt mode
// RULE16: host walks channel and source bits
// RULE17: host drains whole blocks while present
// RULE18: polling uses same routine on a timer
// RULE19: good status: top bit, count up to 127
// RULE20: near-full and overrun clear on last byte
// RULE21: flag to data starts message, zeros unstuffed
// RULE22: threshold programmable from 2 to 127
// RULE23: error code and depth fixed by parameter
module hrx_rx_link_unit #(
  parameter int AW = 7                  // fifo depth is 2**AW bytes
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        dl_bit_en,     // one-cycle enable per link bit
  input  wire logic        dl_bit,        // link bit, first bit first
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest
);
  import hrx_pkg::*;
  localparam int DEPTH = 2**AW;            // RULE23

  // address match, shared by read and write decode
  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // control state written by software
  logic        en_r;          // unit enable
  logic        en_d_r;        // enable delayed, for the start pulse
  logic        nfie_r;        // near_full_irq_enable
  logic        msgie_r;       // msg_irq_enable
  logic        ovrie_r;       // overrun_irq_enable
  logic [6:0]  thr_r;         // near-full threshold
  // fifo pointers, one extra bit tells full from empty
  logic [AW:0] wptr_r;        // next free byte
  logic [AW:0] rptr_r;        // next byte to read
  logic [AW:0] cptr_r;        // end of completed blocks
  logic [AW:0] bst_r;         // reserved status slot of open block
  logic [6:0]  bcnt_r;        // data bytes in open block
  logic        open_r;        // a block is open
  logic        pend_b_r;      // errored status waits for a slot
  logic        disc_r;        // not collecting message data
  // indications
  logic        nf_r;          // near_full_flag
  logic        msg_r;         // msg_received_flag
  logic        ovr_r;         // overrun_flag
  // bus handshake
  logic        rd_ack_r;      // read answered this cycle
  logic [31:0] rdata_r;       // captured read data
  logic [31:0] rd_mux;        // read answer before capture
  // storage: byte plus its kind and goodness
  logic [7:0]  mem_r  [DEPTH];
  logic        stat_r [DEPTH];
  logic        good_r [DEPTH];

  hrx_link_if lk ();

  // bit-level framing runs only while enabled
  hrx_deframer u_dfr (
    .clk     (clk),
    .reset_n (reset_n),
    .enable  (en_r),
    .bit_en  (dl_bit_en),
    .bit_in  (dl_bit),
    .lk      (lk.dfr)
  );

  // fill level and read side views
  wire [AW:0]   occ    = wptr_r - rptr_r;
  wire [AW:0]   occ1   = occ + 1'b1;
  wire [AW:0]   thr_x  = (AW+1)'(thr_r);
  wire          full   = occ[AW];
  wire [AW-1:0] ra     = rptr_r[AW-1:0];
  // only bytes below the commit point are readable
  wire          blk    = (rptr_r != cptr_r);                    // RULE10 RULE11
  wire          next_st = blk & stat_r[ra];                     // RULE13
  wire          good_nx = next_st & good_r[ra];
  wire          irq_mode = nfie_r | msgie_r;                    // RULE15
  wire          start  = en_r & ~en_d_r;

  // bus decode; reads take one wait cycle, writes none
  wire rd_cap  = avs_read & ~rd_ack_r;
  wire wr_acc  = avs_write;
  wire pop     = rd_cap & hit(avs_address, `HRX_OFS_MSG) & blk; // RULE9 RULE11
  wire last_rd = pop & (rptr_r + 1'b1 == cptr_r);
  wire st_cap  = rd_cap & hit(avs_address, `HRX_OFS_STAT);

  // message events, ignored while discarding
  wire take    = lk.octet_vld & ~disc_r;
  wire ovr_ev  = take & (~open_r | full) & ~ovr_r;              // RULE6
  wire wr_d    = take & open_r & ~full;
  wire nf_d    = wr_d & (occ1 >= thr_x) & ~nf_r;                // RULE3
  wire len_cap = wr_d & (bcnt_r == `HRX_LEN_LAST);
  wire eom_ok  = lk.eom & ~disc_r & open_r & ~lk.align_err;
  wire eom_bad = lk.eom & ~disc_r & open_r & lk.align_err;
  wire abt     = lk.abrt & ~disc_r & open_r;                    // RULE1
  // a new status slot is taken as soon as there is room
  wire res     = en_r & ~start & ~open_r & ~full;               // RULE12 RULE7
  wire res_b   = res & pend_b_r;                                // RULE7
  wire nf_s    = res & ~pend_b_r & (occ1 >= thr_x) & ~nf_r;     // RULE5

  // block close: which status byte, where, and whether data is dropped
  logic       close;
  logic       drop;
  logic       cgood;
  logic [7:0] cst;
  logic [AW:0] sa;
  always_comb begin
    close = 1'b1;
    drop  = 1'b0;
    cgood = 1'b0;
    cst   = 8'h00;
    sa    = bst_r;
    if (ovr_ev && open_r) begin                                 // RULE6
      drop = 1'b1;
      cst  = {1'b0, `HRX_ERR_OVR, 5'h00};
    end else if (eom_bad) begin
      drop = 1'b1;
      cst  = {1'b0, `HRX_ERR_ALIGN, 5'h00};
    end else if (abt) begin                                     // RULE1
      drop = 1'b1;
      cst  = {1'b0, `HRX_ERR_ABORT, 5'h00};
    end else if (eom_ok) begin                                  // RULE19 RULE4
      cgood = 1'b1;
      cst   = {1'b1, bcnt_r};
    end else if (nf_d || len_cap) begin                         // RULE3
      cst = {1'b0, bcnt_r + 7'h01};
    end else if (res_b) begin                                   // RULE7
      sa  = wptr_r;
      cst = {1'b0, `HRX_ERR_OVR, 5'h00};
    end else if (nf_s) begin                                    // RULE5
      sa  = wptr_r;
    end else begin
      close = 1'b0;
    end
  end

  // write pointer: reserve, append, or rewind over dropped data
  logic [AW:0] wptr_nxt;
  always_comb begin
    wptr_nxt = wptr_r;
    if (start) wptr_nxt = '0;
    else if (drop) wptr_nxt = bst_r + 1'b1;                     // RULE1
    else if (wr_d || res) wptr_nxt = wptr_r + 1'b1;
  end

  // software registers and the read answer
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      en_r     <= 1'b0;
      nfie_r   <= 1'b0;
      msgie_r  <= 1'b0;
      ovrie_r  <= 1'b0;
      thr_r    <= `HRX_THR_RST;
      rd_ack_r <= 1'b0;
      rdata_r  <= 32'h0000_0000;
    end else begin
      rd_ack_r <= rd_cap;
      if (wr_acc && hit(avs_address, `HRX_OFS_CTRL)) begin
        en_r    <= avs_writedata[`HRX_CTRL_EN];
        nfie_r  <= avs_writedata[`HRX_CTRL_NFIE];
        msgie_r <= avs_writedata[`HRX_CTRL_MSGIE];
        ovrie_r <= avs_writedata[`HRX_CTRL_OVRIE];
      end
      // values below the lower limit are raised to it
      if (wr_acc && hit(avs_address, `HRX_OFS_THR))
        thr_r <= (avs_writedata[6:0] < `HRX_THR_MIN) ? `HRX_THR_MIN : avs_writedata[6:0]; // RULE22
      if (rd_cap) rdata_r <= rd_mux;
    end
  end

  // read multiplexer; unmapped offsets and empty fifo read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit(avs_address, `HRX_OFS_CTRL)) begin
      rd_mux[`HRX_CTRL_EN]    = en_r;
      rd_mux[`HRX_CTRL_NFIE]  = nfie_r;
      rd_mux[`HRX_CTRL_MSGIE] = msgie_r;
      rd_mux[`HRX_CTRL_OVRIE] = ovrie_r;
    end else if (hit(avs_address, `HRX_OFS_THR)) begin
      rd_mux[6:0] = thr_r;
    end else if (hit(avs_address, `HRX_OFS_STAT)) begin
      rd_mux[`HRX_ST_NF]   = nf_r;
      rd_mux[`HRX_ST_MSG]  = msg_r;
      rd_mux[`HRX_ST_OVR]  = ovr_r;
      rd_mux[`HRX_ST_BLK]  = blk;                               // RULE11
      rd_mux[`HRX_ST_GOOD] = good_nx;
      rd_mux[`HRX_ST_NEXT] = next_st;                           // RULE13
      rd_mux[`HRX_ST_IRQM] = irq_mode;
    end else if (hit(avs_address, `HRX_OFS_MSG) && blk) begin
      rd_mux[7:0] = mem_r[ra];
    end
  end

  assign avs_waitrequest = avs_read & ~rd_ack_r;
  assign avs_readdata    = rdata_r;

  // block assembly; a fresh enable empties the fifo and clears flags
  always_ff @(posedge clk) begin
    if (!reset_n || start) begin
      en_d_r   <= reset_n & en_r;
      wptr_r   <= '0;
      rptr_r   <= '0;
      cptr_r   <= '0;
      bst_r    <= '0;
      bcnt_r   <= 7'h00;
      open_r   <= 1'b0;
      pend_b_r <= 1'b0;
      disc_r   <= 1'b1;
      nf_r     <= 1'b0;
      msg_r    <= 1'b0;
      ovr_r    <= 1'b0;
    end else begin
      en_d_r <= en_r;
      wptr_r <= wptr_nxt;
      if (pop) rptr_r <= rptr_r + 1'b1;                         // RULE9
      if (close) cptr_r <= wptr_nxt;                            // RULE10
      if (res) bst_r <= wptr_r;
      if (res) bcnt_r <= 7'h00;
      else if (wr_d) bcnt_r <= bcnt_r + 7'h01;
      open_r <= close ? 1'b0 : (res | open_r);
      if (res) pend_b_r <= 1'b0;
      else if (ovr_ev && !open_r) pend_b_r <= 1'b1;             // RULE7
      // resume only on a flag-to-data transition with overrun clear
      if (ovr_ev) disc_r <= 1'b1;                               // RULE8
      else if (lk.sof && !ovr_r) disc_r <= 1'b0;                // RULE8 RULE2
      // set wins over clear for every flag
      nf_r  <= (nf_d | nf_s) | (nf_r & ~last_rd);               // RULE20
      ovr_r <= ovr_ev | (ovr_r & ~last_rd);                     // RULE20
      msg_r <= (lk.eom | lk.abrt) | (msg_r & ~st_cap);          // RULE1
    end
  end

  // storage writes carry no reset, contents are guarded by pointers
  always_ff @(posedge clk) begin
    if (wr_d) begin
      mem_r[wptr_r[AW-1:0]]  <= lk.octet;
      stat_r[wptr_r[AW-1:0]] <= 1'b0;
    end
    if (close) begin
      mem_r[sa[AW-1:0]]  <= cst;
      stat_r[sa[AW-1:0]] <= 1'b1;                               // RULE12
      good_r[sa[AW-1:0]] <= cgood;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_pop;
    pop && !start |=> rptr_r == $past(rptr_r) + 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("read did not advance"); // RULE9

  property p_empty_read;
    rd_cap && hit(avs_address, `HRX_OFS_MSG) && !blk && !start |=> $stable(rptr_r);
  endproperty
  a_empty_read: assert property (p_empty_read) else $error("empty read moved pointer"); // RULE11

  property p_commit_bound;
    (cptr_r - rptr_r) <= (wptr_r - rptr_r);
  endproperty
  a_commit_bound: assert property (p_commit_bound) else $error("commit past write point"); // RULE10

  property p_ovr_set;
    ovr_ev && !start |=> ovr_r && disc_r;
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not raised"); // RULE6

  property p_nf_set;
    nf_d && !start |=> nf_r && !open_r ##1 open_r || full;
  endproperty
  a_nf_set: assert property (p_nf_set) else $error("near-full close wrong"); // RULE3

  property p_flag_clear;
    $fell(nf_r) || $fell(ovr_r) |-> $past(last_rd) || $past(start);
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag cleared early"); // RULE20

  property p_abort_msg;
    abt && !start |=> msg_r && wptr_r == $past(bst_r) + 1'b1;
  endproperty
  a_abort_msg: assert property (p_abort_msg) else $error("abort block wrong"); // RULE1

  property p_good_byte;
    eom_ok && !start |=> stat_r[$past(bst_r[AW-1:0])] && good_r[$past(bst_r[AW-1:0])]
      && mem_r[$past(bst_r[AW-1:0])][7];
  endproperty
  a_good_byte: assert property (p_good_byte) else $error("good status byte wrong"); // RULE19

  property p_read_wait;
    avs_read && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read not answered"); // RULE9

  property p_thr_range;
    thr_r >= `HRX_THR_MIN;
  endproperty
  a_thr_range: assert property (p_thr_range) else $error("threshold out of range"); // RULE22

  c_good_msg: cover property (eom_ok);
  c_near_full: cover property (nf_d ##[1:300] eom_ok);
  c_overrun: cover property (ovr_ev ##[1:1000] last_rd);
  c_pend_status: cover property (res_b);
endmodule : hrx_rx_link_unit

// file: tb/hrx_host_model.sv
`timescale 1ns/100ps
// avalon master standing in for the host processor
module hrx_host_model (
  input  wire logic        clk,
  output logic      [3:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  input  wire logic        avs_waitrequest
);
  int tmo_cnt = 0;  // accesses whose wait ran out

  // bus idles with nothing requested
  initial begin
    avs_address   = 4'h0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = 32'h0000_0000;
  end

  // one access; the request rises just after an edge and stands until a
  // rising edge samples waitrequest low, which completes it, or the wait runs out; only then is
  // it dropped, so a second call always lets one edge pass in between
  task acc(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_read      <= ~wr;
    avs_write     <= wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n == 50) tmo_cnt++;  // bus hang
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask : acc
endmodule : hrx_host_model

// file: tb/test_hdlc_data_link_rx_fifo.sv
`timescale 1ns/100ps
`include "hrx_defines.svh"
module test_hdlc_data_link_rx_fifo;
  import hrx_pkg::*;
  logic        clk       = 1'b0;
  logic        reset_n   = 1'b0;
  logic        dl_bit_en = 1'b0;
  logic        dl_bit    = 1'b0;
  logic [3:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [63:0] exp_q[$];  // notes: {mask, value}
  logic [63:0] e;         // note being compared
  logic [7:0]  dat[$];    // payload sent
  int          error_cnt = 0;
  int          checks    = 0;
  int          ones      = 0;  // run of ones for stuffing

  // 125 MHz clock
  initial forever #4 clk = ~clk;

  hrx_host_model host (
    .clk             (clk),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_waitrequest (avs_waitrequest)
  );

  hrx_rx_link_unit #(
    .AW (4)  // 16-byte fifo so overrun comes quickly
  ) dut (
    .clk             (clk),
    .reset_n         (reset_n),
    .dl_bit_en       (dl_bit_en),
    .dl_bit          (dl_bit),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest)
  );

  task check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
    checks++;
    if (seen !== ex) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task close_out;
    error_cnt += host.tmo_cnt + exp_q.size();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : close_out

  // a completed read takes the oldest note
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
      if (exp_q.size() == 0) check("unexpected read", 32'h0000_0001, 32'h0000_0000);
      else begin
        e = exp_q.pop_front();
        check("readdata", avs_readdata & e[63:32], e[31:0]);
      end
    end
  end

  // hang guard
  initial begin
    #800000;
    error_cnt++;
    close_out();
  end

  // note the answer, then read; upper bits must be zero
  task rdx(input logic [3:0] a, input logic [7:0] v, input logic [7:0] m);
    exp_q.push_back({24'hFF_FFFF, m, 24'h00_0000, v & m});
    host.acc(1'b0, a, 32'h0000_0000);
    if (host.tmo_cnt != 0) close_out();  // a dead bus ends the run
  endtask : rdx

  task wr(input logic [3:0] a, input logic [31:0] d);
    host.acc(1'b1, a, d);
    if (host.tmo_cnt != 0) close_out();  // a dead bus ends the run
  endtask : wr

  // one link bit, random spacing; line shows the inverse between bits
  task lb(input logic b);
    repeat ($urandom_range(0, 2)) @(posedge clk);
    @(posedge clk);
    dl_bit    <= b;
    dl_bit_en <= 1'b1;
    @(posedge clk);
    dl_bit    <= ~b;
    dl_bit_en <= 1'b0;
  endtask : lb

  task flag;
    logic [7:0] f;
    f = 8'h7E;
    for (int i = 0; i < 8; i++) lb(f[i]);
    ones = 0;
  endtask : flag

  task abrt;
    repeat (8) lb(1'b1);
    ones = 0;
  endtask : abrt

  // data byte, lsb first, zero stuffed after five ones
  task dbyte(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      lb(d[i]);
      ones = d[i] ? ones + 1 : 0;
      if (ones == 5) begin
        lb(1'b0);
        ones = 0;
      end
    end
  endtask : dbyte

  // status byte read: {irq mode, next, good, blk, ovr, msg, nf}
  initial begin
    void'($urandom(53908));
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    rdx(`HRX_OFS_THR, 8'h20, 8'hFF);
    wr(`HRX_OFS_THR, 32'h0000_0001);
    rdx(`HRX_OFS_THR, 8'h02, 8'hFF);
    wr(`HRX_OFS_THR, 32'h0000_000F);
    wr(4'h2, 32'h0000_00FF);
    rdx(4'h2, 8'h00, 8'hFF);
    wr(`HRX_OFS_CTRL, 32'h0000_0005);
    rdx(`HRX_OFS_CTRL, 8'h05, 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h40, 8'hC7);
    rdx(`HRX_OFS_MSG, 8'h00, 8'hFF);
    // good message, first byte forces a stuffed zero
    dat = {8'hFF};
    repeat ($urandom_range(1, 3)) dat.push_back(8'($urandom));
    flag();
    foreach (dat[i]) dbyte(dat[i]);
    flag();
    repeat (12) @(posedge clk);
    rdx(`HRX_OFS_STAT, 8'h7A, 8'hFF);
    rdx(`HRX_OFS_MSG, 8'h80 | 8'(dat.size()), 8'hFF);
    foreach (dat[i]) rdx(`HRX_OFS_MSG, dat[i], 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h40, 8'hC7);
    // abort, then data without a flag is ignored
    flag();
    dbyte(8'h12);
    dbyte(8'h34);
    abrt();
    dbyte(8'h56);
    dbyte(8'h78);
    flag();
    dbyte(8'h55);
    flag();
    repeat (12) @(posedge clk);
    rdx(`HRX_OFS_STAT, 8'h6A, 8'hFF);
    rdx(`HRX_OFS_MSG, {1'b0, `HRX_ERR_ABORT, 5'h00}, 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h78, 8'hFF);
    rdx(`HRX_OFS_MSG, 8'h81, 8'hFF);
    rdx(`HRX_OFS_MSG, 8'h55, 8'hFF);
    // long message fills the fifo: partial block, then overrun
    dat.delete();
    repeat (20) dat.push_back(8'($urandom));
    flag();
    foreach (dat[i]) dbyte(dat[i]);
    flag();
    flag();
    dbyte(8'h22);
    flag();
    repeat (12) @(posedge clk);
    rdx(`HRX_OFS_STAT, 8'h6D, 8'hFD);
    rdx(`HRX_OFS_MSG, 8'h0E, 8'hFF);
    for (int i = 0; i < 14; i++) rdx(`HRX_OFS_MSG, dat[i], 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h6D, 8'hFD);
    rdx(`HRX_OFS_MSG, {1'b0, `HRX_ERR_OVR, 5'h00}, 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h40, 8'hC5);
    rdx(`HRX_OFS_MSG, 8'h00, 8'hFF);
    // polling mode from here: both functional interrupt enables off
    wr(`HRX_OFS_CTRL, 32'h0000_0009);
    rdx(`HRX_OFS_CTRL, 8'h09, 8'hFF);
    // storing resumes on a fresh flag to data
    flag();
    dbyte(8'h11);
    flag();
    repeat (12) @(posedge clk);
    rdx(`HRX_OFS_STAT, 8'h38, 8'hFD);
    rdx(`HRX_OFS_MSG, 8'h81, 8'hFF);
    rdx(`HRX_OFS_MSG, 8'h11, 8'hFF);
    // message ends on the threshold byte and fills the fifo: an empty good
    // block, then the next message finds no slot and its status waits
    dat.delete();
    repeat (14) dat.push_back(8'($urandom));
    flag();
    foreach (dat[i]) dbyte(dat[i]);
    flag();
    dbyte(8'h33);
    flag();
    repeat (12) @(posedge clk);
    rdx(`HRX_OFS_STAT, 8'h2D, 8'hFD);
    rdx(`HRX_OFS_MSG, 8'h0E, 8'hFF);
    foreach (dat[i]) rdx(`HRX_OFS_MSG, dat[i], 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h3D, 8'hFD);
    rdx(`HRX_OFS_MSG, 8'h80, 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h2D, 8'hFD);
    rdx(`HRX_OFS_MSG, {1'b0, `HRX_ERR_OVR, 5'h00}, 8'hFF);
    rdx(`HRX_OFS_STAT, 8'h00, 8'hC5);
    repeat (5) @(posedge clk);
    close_out();
  end
endmodule : test_hdlc_data_link_rx_fifo
